// >>> hdl/rsc_core.sv
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/1ns
module rsc_core
  import rsc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Program memory
  output logic [12:0] prog_addr,
  input wire logic [13:0] instr_data,
  // General purpose pins
  input wire logic [3:0] gpio_in,
  output logic [3:0] gpio_out,
  output logic [3:0] gpio_oe,
  // Power management pulses
  output logic standby_pulse,
  output logic watchdog_kick,
  // Software register port
  input wire rsc_bus_type bus,
  output logic [7:0] bus_rdata
);

  rsc_state_type s; // Registered state
  rsc_state_type n; // Next state

  // Decode and datapath helpers
  logic exec_en; // Q4 of a running cycle
  logic [13:0] op; // Instruction being executed
  logic [6:0] f; // File operand address
  logic [2:0] bsel; // Bit position
  logic [7:0] k8; // Literal
  logic [7:0] fval; // Operand as read
  logic [7:0] res; // Datapath result
  logic wr_w; // Result to accumulator
  logic wr_f; // Result to file register
  logic upd_z; // Zero flag changes
  logic upd_cdc; // Carry and nibble carry change
  logic upd_c; // Carry alone changes
  logic new_c; // New carry
  logic new_nc; // New nibble carry
  logic skip; // Discard next fetched word
  logic is_jump; // Unconditional jump
  logic is_call; // Subroutine call
  logic is_ret; // Pop return address
  logic is_irq_exit; // Interrupt exit
  logic is_sleep; // Standby request
  logic is_kick; // Watchdog restart
  logic [9:0] sum; // {dc, c, result} from the adder
  logic tmr_tick; // Timer advances this cycle
  logic [7:0] pmask; // Prescaler rate mask

  // Carry-aware adder shared by all add and subtract forms
  function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b, input logic cin);
    logic [4:0] lo;
    logic [4:0] hi;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
    return {lo[4], hi[4], hi[3:0], lo[3:0]};
  endfunction

  // Operand fetch with the special-register views
  function automatic logic [7:0] file_rd(input logic [127:0][7:0] ram, input logic [6:0] adr,
                                         input logic [7:0] tmr, input logic [7:0] pc_lo,
                                         input logic [3:0] pins);
    case (adr)
      ADR_TIMER: return tmr;
      ADR_PC_LOW: return pc_lo;
      ADR_DIR: return ram[adr] | DIR_IN_ONLY;
      ADR_PORT: return {4'h0, pins};
      default: return ram[adr];
    endcase
  endfunction

  // Execution happens once per four phases; a flushed slot runs as idle
  assign exec_en = s.run_r && (s.phase_r == PH_Q4);
  assign op = s.flush_r ? IDLE_WORD : s.ir_r;
  assign f = op[6:0];
  assign bsel = op[9:7];
  assign k8 = op[7:0];
  assign fval = file_rd(s.ram_r, f, s.timer_r, s.pc_r[7:0], s.pin_stable_r);
  assign pmask = 8'hFF >> (3'd7 - s.ram_r[ADR_OPTION][2:0]);

  // Outputs come straight from state
  assign prog_addr = s.pc_r;
  assign gpio_out = s.ram_r[ADR_PORT][3:0];
  assign gpio_oe = ~s.ram_r[ADR_DIR][3:0] & OE_ALLOWED;
  assign standby_pulse = s.standby_r;
  assign watchdog_kick = s.kick_r;
  assign bus_rdata = s.rdata_r;

  // Decode, datapath and next state
  always_comb begin
    n = s;
    n.standby_r = 1'b0;
    n.kick_r = 1'b0;
    n.rdata_r = 8'h00;
    res = 8'h00;
    wr_w = 1'b0;
    wr_f = 1'b0;
    upd_z = 1'b0;
    upd_cdc = 1'b0;
    upd_c = 1'b0;
    new_c = s.ram_r[ADR_STATUS][ST_C];
    new_nc = s.ram_r[ADR_STATUS][ST_NC];
    skip = 1'b0;
    is_jump = 1'b0;
    is_call = 1'b0;
    is_ret = 1'b0;
    is_irq_exit = 1'b0;
    is_sleep = 1'b0;
    is_kick = 1'b0;
    sum = 10'h000;
    tmr_tick = 1'b0;

    // Pin synchroniser; a change counts once stages two and three agree
    n.pin_sync_r[0] = gpio_in;
    n.pin_sync_r[1] = s.pin_sync_r[0];
    n.pin_sync_r[2] = s.pin_sync_r[1];
    if (s.pin_sync_r[1] == s.pin_sync_r[2]) begin
      n.pin_stable_r = s.pin_sync_r[2];
    end

    // Phase counter free-runs while enabled
    if (s.run_r) begin
      n.phase_r = rsc_phase_type'(s.phase_r + 2'b01);
    end

    // Instruction decode
    case (op[13:12])
      2'b00: begin
        // Byte-oriented; d picks the destination
        wr_f = op[7];
        wr_w = !op[7];
        case (op[11:8])
          4'b0111: begin
            sum = add8(s.w_r, fval, 1'b0);
            res = sum[7:0];
            upd_cdc = 1'b1;
            upd_z = 1'b1;
          end
          4'b0010: begin
            sum = add8(fval, ~s.w_r, 1'b1);
            res = sum[7:0];
            upd_cdc = 1'b1;
            upd_z = 1'b1;
          end
          4'b0100: begin
            res = s.w_r | fval;
            upd_z = 1'b1;
          end
          4'b0110: begin
            res = s.w_r ^ fval;
            upd_z = 1'b1;
          end
          4'b0101: begin
            res = s.w_r & fval;
            upd_z = 1'b1;
          end
          4'b1101: begin
            res = {fval[6:0], s.ram_r[ADR_STATUS][ST_C]};
            new_c = fval[7];
            upd_c = 1'b1;
          end
          4'b1100: begin
            res = {s.ram_r[ADR_STATUS][ST_C], fval[7:1]};
            new_c = fval[0];
            upd_c = 1'b1;
          end
          4'b1011: begin
            res = fval - 8'h01;
            skip = (res == 8'h00);
          end
          4'b1111: begin
            res = fval + 8'h01;
            skip = (res == 8'h00);
          end
          4'b1000: begin
            res = fval;
            upd_z = 1'b1;
          end
          4'b1001: begin
            res = ~fval;
            upd_z = 1'b1;
          end
          4'b0011: begin
            res = fval - 8'h01;
            upd_z = 1'b1;
          end
          4'b1010: begin
            res = fval + 8'h01;
            upd_z = 1'b1;
          end
          4'b1110: begin
            res = {fval[3:0], fval[7:4]};
          end
          4'b0001: begin
            // Clear register or accumulator; low bits of the accumulator form are ignored
            res = 8'h00;
            upd_z = 1'b1;
          end
          4'b0000: begin
            wr_w = 1'b0;
            res = s.w_r;
            if (!op[7]) begin
              // Control words; anything else here is idle
              case (op[7:0])
                LO_RETURN: is_ret = 1'b1;
                LO_IRQ_EXIT: begin
                  is_ret = 1'b1;
                  is_irq_exit = 1'b1;
                end
                LO_SLEEP: is_sleep = 1'b1;
                LO_KICK: is_kick = 1'b1;
                default: ;
              endcase
            end
          end
          default: begin
            wr_f = 1'b0;
            wr_w = 1'b0;
          end
        endcase
      end
      2'b01: begin
        // Bit-oriented; the whole byte is read; set and clear change one bit and write it all back, tests only skip
        res = fval;
        case (op[11:10])
          2'b00: begin
            res[bsel] = 1'b0;
            wr_f = 1'b1;
          end
          2'b01: begin
            res[bsel] = 1'b1;
            wr_f = 1'b1;
          end
          2'b10: skip = !fval[bsel];
          default: skip = fval[bsel];
        endcase
      end
      2'b10: begin
        is_jump = op[11];
        is_call = !op[11];
      end
      default: begin
        // Literal forms; x bits are never looked at
        wr_w = 1'b1;
        casez (op[11:8])
          4'b00??: res = k8;
          4'b01??: begin
            res = k8;
            is_ret = 1'b1;
          end
          4'b1000: begin
            res = s.w_r | k8;
            upd_z = 1'b1;
          end
          4'b1010: begin
            res = s.w_r ^ k8;
            upd_z = 1'b1;
          end
          4'b1001: begin
            res = s.w_r & k8;
            upd_z = 1'b1;
          end
          4'b110?: begin
            sum = add8(k8, ~s.w_r, 1'b1);
            res = sum[7:0];
            upd_cdc = 1'b1;
            upd_z = 1'b1;
          end
          4'b111?: begin
            sum = add8(k8, s.w_r, 1'b0);
            res = sum[7:0];
            upd_cdc = 1'b1;
            upd_z = 1'b1;
          end
          default: wr_w = 1'b0;
        endcase
      end
    endcase
    if (upd_cdc) begin
      new_c = sum[8];
      new_nc = sum[9];
    end

    // Commit at the end of the instruction cycle
    if (exec_en) begin
      n.ir_r = instr_data;
      n.flush_r = 1'b0;
      n.pc_r = s.pc_r + 13'h0001;
      // Prescaler runs only while assigned to the timer
      if (!s.ram_r[ADR_OPTION][OPT_PSA]) begin
        n.presc_r = s.presc_r + 8'h01;
        tmr_tick = ((s.presc_r & pmask) == pmask);
      end else begin
        tmr_tick = 1'b1;
      end
      if (tmr_tick) begin
        n.timer_r = s.timer_r + 8'h01;
      end
      if (wr_w) begin
        n.w_r = res;
      end
      if (wr_f) begin
        case (f)
          ADR_TIMER: begin
            n.timer_r = res;
            if (!s.ram_r[ADR_OPTION][OPT_PSA]) begin
              n.presc_r = 8'h00;
            end
          end
          ADR_PC_LOW: begin
            n.pc_r = {s.ram_r[ADR_PC_LATCH][4:0], res};
            n.flush_r = 1'b1;
          end
          default: n.ram_r[f] = res;
        endcase
      end
      // Flags are applied after the store so they win over written bits
      if (upd_z) begin
        n.ram_r[ADR_STATUS][ST_Z] = (res == 8'h00);
      end
      if (upd_cdc || upd_c) begin
        n.ram_r[ADR_STATUS][ST_C] = new_c;
      end
      if (upd_cdc) begin
        n.ram_r[ADR_STATUS][ST_NC] = new_nc;
      end
      if (is_sleep) begin
        n.ram_r[ADR_STATUS][ST_TO] = 1'b1;
        n.ram_r[ADR_STATUS][ST_PWDN] = 1'b0;
        n.standby_r = 1'b1;
        n.kick_r = 1'b1;
      end
      if (is_kick) begin
        n.ram_r[ADR_STATUS][ST_TO] = 1'b1;
        n.ram_r[ADR_STATUS][ST_PWDN] = 1'b1;
        n.kick_r = 1'b1;
      end
      if (skip) begin
        n.flush_r = 1'b1;
      end
      if (is_jump || is_call) begin
        n.pc_r = {s.ram_r[ADR_PC_LATCH][4:3], op[10:0]};
        n.flush_r = 1'b1;
      end
      if (is_call) begin
        n.stack_r[s.sp_r] = s.pc_r;
        n.sp_r = s.sp_r + 3'd1;
      end
      if (is_ret) begin
        n.pc_r = s.stack_r[s.sp_r - 3'd1];
        n.sp_r = s.sp_r - 3'd1;
        n.flush_r = 1'b1;
      end
      if (is_irq_exit) begin
        n.ram_r[ADR_INTCON][GATE_BIT] = 1'b1;
      end
    end

    // Software port: control write and one-cycle-late read data
    if (bus.wr && (bus.addr == REG_CTRL)) begin
      n.run_r = bus.wdata[0];
    end
    if (bus.rd) begin
      case (bus.addr)
        REG_CTRL: n.rdata_r = {7'h00, s.run_r};
        REG_ACC: n.rdata_r = s.w_r;
        REG_STATUS: n.rdata_r = s.ram_r[ADR_STATUS];
        REG_PC_LO: n.rdata_r = s.pc_r[7:0];
        REG_PC_HI: n.rdata_r = {3'h0, s.pc_r[12:8]};
        default: n.rdata_r = 8'h00;
      endcase
    end
  end

  // State register with synchronous reset; first slot flushed
  always_ff @(posedge mclk) begin
    if (reset) begin
      s <= '0;
      s.ram_r[ADR_STATUS] <= STATUS_RST;
      s.run_r <= 1'b1;
      s.flush_r <= 1'b1;
    end else begin
      s <= n;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  a_cycle_four_phases: assert property ((s.run_r && s.phase_r == PH_Q1) |-> ##3 exec_en)
    else $error("execute slot not on fourth phase");
  a_branch_flush: assert property ((exec_en && (is_jump || is_call || is_ret)) |=> s.flush_r)
    else $error("branch did not insert idle cycle");
  a_dest_acc: assert property ((exec_en && op[13:12] == 2'b00 && op[11:8] == 4'b0111 && !op[7])
    |=> s.w_r == $past(res))
    else $error("add result missing from accumulator");
  a_logic_zero: assert property ((exec_en && op[13:12] == 2'b11 && op[11:8] == 4'b1001)
    |=> s.ram_r[ADR_STATUS][ST_Z] == (s.w_r == 8'h00))
    else $error("literal and zero flag wrong");
  a_rotate_carry: assert property ((exec_en && op[13:8] == 6'b001101)
    |=> s.ram_r[ADR_STATUS][ST_C] == $past(fval[7]))
    else $error("rotate left carry wrong");
  a_skip_zero: assert property ((exec_en && op[13:8] == 6'b001011 && fval == 8'h01)
    |=> s.flush_r ##4 !s.flush_r)
    else $error("decrement skip not one cycle");
  a_status_clear: assert property ((exec_en && op[13:7] == 7'b0000011 && f == ADR_STATUS)
    |=> (s.ram_r[ADR_STATUS] & 8'hE7) == 8'h04)
    else $error("cleared status not left with zero set");
  a_dir_bit3: assert property ((exec_en && f == ADR_DIR && op[13:12] != 2'b10) |-> fval[3])
    else $error("direction bit three read low");
  a_call_push: assert property ((exec_en && is_call)
    |=> s.stack_r[$past(s.sp_r)] == $past(s.pc_r))
    else $error("call did not push return address");
  a_timer_presc: assert property ((exec_en && wr_f && f == ADR_TIMER && !s.ram_r[ADR_OPTION][OPT_PSA])
    |=> s.presc_r == 8'h00)
    else $error("timer write left prescaler running");

  c_call_taken: cover property (exec_en && is_call);
  c_skip_taken: cover property (exec_en && skip);
  c_literal_return: cover property (exec_en && is_ret && wr_w);
  c_low_byte_write: cover property (exec_en && wr_f && f == ADR_PC_LOW);
endmodule

// >>> hdl/rsc_pkg.sv
package rsc_pkg;
  // File register map
  localparam logic [6:0] ADR_TIMER = 7'h01;
  localparam logic [6:0] ADR_PC_LOW = 7'h02;
  localparam logic [6:0] ADR_STATUS = 7'h03;
  localparam logic [6:0] ADR_DIR = 7'h05;
  localparam logic [6:0] ADR_PORT = 7'h06;
  localparam logic [6:0] ADR_OPTION = 7'h07;
  localparam logic [6:0] ADR_PC_LATCH = 7'h0A;
  localparam logic [6:0] ADR_INTCON = 7'h0B;
  // Status, option and gate bit positions
  localparam int ST_C = 0;
  localparam int ST_NC = 1;
  localparam int ST_Z = 2;
  localparam int ST_PWDN = 3;
  localparam int ST_TO = 4;
  localparam int OPT_PSA = 3;
  localparam int GATE_BIT = 7;
  localparam logic [7:0] STATUS_RST = 8'h18;
  localparam logic [7:0] DIR_IN_ONLY = 8'h08;
  localparam logic [3:0] OE_ALLOWED = 4'h7;
  localparam logic [13:0] IDLE_WORD = 14'h0000;
  // Control-word low bytes under the all-zero prefix
  localparam logic [7:0] LO_RETURN = 8'h08;
  localparam logic [7:0] LO_IRQ_EXIT = 8'h09;
  localparam logic [7:0] LO_SLEEP = 8'h63;
  localparam logic [7:0] LO_KICK = 8'h64;
  // Software port map
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ACC = 4'h1;
  localparam logic [3:0] REG_STATUS = 4'h2;
  localparam logic [3:0] REG_PC_LO = 4'h3;
  localparam logic [3:0] REG_PC_HI = 4'h4;
  localparam int PHASES_PER_CYCLE = 4;
  localparam int STACK_DEPTH = 8;

  // Four oscillator phases of one instruction cycle
  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b10,
    PH_Q4 = 2'b11
  } rsc_phase_type;

  // Register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rsc_bus_type;

  // Whole core state
  typedef struct packed {
    logic [127:0][7:0] ram_r;
    logic [7:0] w_r;
    logic [12:0] pc_r;
    logic [13:0] ir_r;
    logic flush_r;
    rsc_phase_type phase_r;
    logic [STACK_DEPTH-1:0][12:0] stack_r;
    logic [2:0] sp_r;
    logic [7:0] timer_r;
    logic [7:0] presc_r;
    logic [2:0][3:0] pin_sync_r;
    logic [3:0] pin_stable_r;
    logic run_r;
    logic [7:0] rdata_r;
    logic standby_r;
    logic kick_r;
  } rsc_state_type;
endpackage

// >>> sim/rsc_prog_mem.sv
`timescale 1ns/1ns
// Program memory at the core's fetch side; answers at once, never stalls
module rsc_prog_mem (
  // Fetch side
  input wire logic [12:0] prog_addr,
  output logic [13:0] instr_data
);
  // Whole 13-bit space, so any counter value lands on a defined word
  logic [13:0] words [0:8191];
  // Combinational answer; the core samples it on its fetch edge
  assign instr_data = words[prog_addr];
endmodule

// >>> sim/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import rsc_pkg::*;
  // Stimulus, all driven at time zero
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] gpio_in = 4'h0;
  rsc_bus_type bus = '0;
  // Design outputs
  logic [12:0] prog_addr;
  logic [13:0] instr_data;
  logic [3:0] gpio_out;
  logic [3:0] gpio_oe;
  logic standby_pulse;
  logic watchdog_kick;
  logic [7:0] bus_rdata;
  // Bookkeeping
  int num_errors = 0;
  int checked = 0;
  int cnt = 0;
  int n_sleep = 0;
  int n_kick = 0;
  logic [13:0] prog [$];
  logic [7:0] rv;

  // 100 MHz clock
  always #5 mclk = ~mclk;

  rsc_core uut (.mclk(mclk), .reset(reset), .prog_addr(prog_addr), .instr_data(instr_data),
    .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .standby_pulse(standby_pulse),
    .watchdog_kick(watchdog_kick), .bus(bus), .bus_rdata(bus_rdata));
  rsc_prog_mem mem (.prog_addr(prog_addr), .instr_data(instr_data));

  // Edges since reset release, and tallies of the power pulses
  always @(posedge mclk) begin
    cnt <= reset ? 0 : cnt + 1;
    if (standby_pulse === 1'b1) n_sleep <= n_sleep + 1;
    if (watchdog_kick === 1'b1) n_kick <= n_kick + 1;
  end

  // Case equality, so an unknown never passes
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Loads the queued program at 0, idle words elsewhere, then resets
  task automatic boot;
    for (int i = 0; i < 8192; i++) mem.words[i] = (i < prog.size()) ? prog[i] : IDLE_WORD;
    @(posedge mclk);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    #1;
  endtask

  // Lands just after edge n counted from reset release
  task automatic wait_to(input int n);
    repeat (n - cnt) @(posedge mclk);
    #1;
  endtask

  // Fetch address standing after edge n
  task automatic addr_at(input int n, input logic [12:0] exp);
    wait_to(n);
    chk({3'h0, prog_addr}, {3'h0, exp});
  endtask

  // One-cycle write strobe, released after the taking edge
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus <= '0;
    #1;
  endtask

  // Read data stands only in the cycle after the taking edge
  task automatic chk_reg(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus <= '0;
    #1;
    rv = bus_rdata;
    chk({8'h00, rv}, {8'h00, exp});
  endtask

  // Literal ops, with don't-care bits set in some words
  task automatic t_literal;
    prog = '{14'h333C, 14'h3803, 14'h3A3F, 14'h3F88, 14'h3E88, 14'h3D10, 14'h385A, 14'h39FF, 14'h2808};
    boot();
    addr_at(4, 13'h0001);
    addr_at(8, 13'h0002);
    addr_at(12, 13'h0003);
    wait_to(60);
    chk_reg(REG_ACC, 8'h5A);
    chk_reg(REG_STATUS, 8'h1B);
    chk_reg(4'hF, 8'h00);
    wr_reg(REG_ACC, 8'hFF);
    chk_reg(REG_ACC, 8'h5A);
    // Freeze lands on a cycle boundary with the loop counter at 08; a running core would show 09 later
    wr_reg(REG_CTRL, 8'h00);
    chk_reg(REG_CTRL, 8'h00);
    chk_reg(REG_PC_LO, 8'h08);
    wait_to(94);
    chk_reg(REG_PC_LO, 8'h08);
    wr_reg(REG_CTRL, 8'h01);
    chk_reg(REG_CTRL, 8'h01);
    $display("literal ops done");
  endtask

  // Register ops with both destinations, rotates, a timer write read back twice, then status cleared
  // The timer write lands on an even prescaler count, so a missed clear would tick once early
  task automatic t_byte;
    prog = '{14'h30A5, 14'h00A0, 14'h300F, 14'h05A0, 14'h0620, 14'h0CA0, 14'h0D20, 14'h0EA0,
      14'h0420, 14'h0081, 14'h0801, 14'h0801, 14'h0720, 14'h0183, 14'h280E};
    boot();
    wait_to(70);
    chk_reg(REG_ACC, 8'h45);
    chk_reg(REG_STATUS, 8'h04);
    $display("byte ops done");
  endtask

  // Counted skips, bit tests, a watchdog kick, and an interrupt exit whose gate bit is then tested
  // Each skipped word would load EE
  task automatic t_skip;
    int k0;
    k0 = n_kick;
    prog = '{14'h3002, 14'h00A1, 14'h0BA1, 14'h0BA1, 14'h30EE, 14'h17A1, 14'h1BA1, 14'h1FA1,
      14'h30EE, 14'h13A1, 14'h1BA1, 14'h30EE, 14'h0F21, 14'h0064, 14'h2012, 14'h1F8B, 14'h30EE,
      14'h2811, 14'h0009};
    boot();
    wait_to(100);
    chk_reg(REG_ACC, 8'h01);
    chk_reg(REG_STATUS, 8'h18);
    chk(16'(n_kick - k0), 16'h0001);
    $display("skip ops done");
  endtask

  // Calls, returns and standby; fetch addresses pin down the idle slots
  task automatic t_call;
    int s0;
    int k0;
    s0 = n_sleep;
    k0 = n_kick;
    prog = '{14'h2005, 14'h3E01, 14'h2007, 14'h2803, 14'h30EE, 14'h3040, 14'h0008, 14'h0063, 14'h3777};
    boot();
    addr_at(8, 13'h0005);
    addr_at(16, 13'h0007);
    addr_at(20, 13'h0001);
    addr_at(32, 13'h0007);
    addr_at(44, 13'h0003);
    wait_to(70);
    chk_reg(REG_ACC, 8'h77);
    chk_reg(REG_STATUS, 8'h10);
    chk(16'(n_sleep - s0), 16'h0001);
    chk(16'(n_kick - k0), 16'h0001);
    $display("call ops done");
  endtask

  // Direction readback, port self-copy from pins, low counter byte write
  task automatic t_pins;
    @(posedge mclk);
    gpio_in <= 4'hA;
    prog = '{14'h3003, 14'h0085, 14'h3007, 14'h0086, 14'h0886, 14'h3001, 14'h008A, 14'h3020,
      14'h0082, 14'h30EE};
    boot();
    mem.words[13'h0120] = 14'h0805;
    mem.words[13'h0121] = 14'h2921;
    addr_at(40, 13'h0120);
    wait_to(80);
    chk_reg(REG_ACC, 8'h0B);
    chk({12'h000, gpio_out}, 16'h000A);
    chk({12'h000, gpio_oe}, 16'h0004);
    chk_reg(REG_PC_HI, 8'h01);
    chk_reg(REG_PC_LO, 8'h21);
    $display("pin ops done");
  endtask

  // Main sequence
  initial begin
    t_literal();
    t_byte();
    t_skip();
    t_call();
    t_pins();
    stop_test();
  end

  // Watchdog: the whole run needs well under 2000 cycles
  initial begin
    #20000;
    num_errors++;
    stop_test();
  end
endmodule
